// ==== srb_map.svh ====
// Offsets, fields, reset values and timing counts of the read-burst link
// Operation
// R1: Read carries column, bank, per-burst auto close
// R2: Auto close shuts row after burst
// R3: First word after latency, then each edge
// R4: Finished burst releases data pins
// R5: Page burst wraps to column zero, continues
// R6: Read truncates read; issue latency minus one early
// R7: Reads accepted every cycle, any bank
// R8: Write may follow last read word directly
// R9: Idle cycle before write avoids contention
// R10: Mask high two clocks before truncating write
// R11: Write after masked read keeps pins released
// R12: Mask low on write command cycle
// R13: Precharge truncates non-auto burst, latency minus one
// R14: No bank command until precharge time elapses
// R15: Optimal precharge equals auto close result
// R16: Burst terminate stops read, latency minus one
// R17: Burst of one needs no mask
// R18: Drive from n+m-1, valid by n+m
// R19: Fixed bursts wrap inside aligned block
// R20: Controller sends no-operation when idle
`ifndef SRB_MAP_SVH
`define SRB_MAP_SVH
`define SRB_OFF_CMD 8'h00
`define SRB_OFF_WDATA 8'h04
`define SRB_OFF_RDATA 8'h08
`define SRB_OFF_STATUS 8'h0C
`define SRB_OFF_CTRL 8'h10
`define SRB_CMD_CODE_LSB 0
`define SRB_CMD_AP_BIT 3
`define SRB_CMD_BANK_LSB 4
`define SRB_CMD_COL_LSB 8
`define SRB_CTRL_LAT_LSB 0
`define SRB_CTRL_BURST_LSB 4
`define SRB_CTRL_TURN_BIT 8
`define SRB_CTRL_RESET 32'h0000_0022
`define SRB_STAT_PEND_BIT 0
`define SRB_STAT_BUSY_BIT 1
`define SRB_STAT_BLOCK_LSB 4
`define SRB_STAT_COUNT_LSB 8
`define SRB_RESP_OKAY 2'h0
`define SRB_RESP_SLVERR 2'h2
`define SRB_CLK_PERIOD_NS 4
`define SRB_ROW_PRECHARGE_TIME_NS 15
`define SRB_ROW_PRECHARGE_CYC \
	((`SRB_ROW_PRECHARGE_TIME_NS + `SRB_CLK_PERIOD_NS - 1) / `SRB_CLK_PERIOD_NS)
`endif

// ==== srb_pkg.sv ====
// Types of the read-burst link, plus the controller's state and register types
package srb_pkg;
	typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_BST} srb_cmd_type;
	typedef enum logic [2:0] {BURST_1, BURST_2, BURST_4, BURST_8, BURST_PAGE} srb_burst_type;
	typedef enum logic [1:0] {CS_IDLE, CS_MASK1, CS_MASK2} srb_ctl_state_type;
	typedef enum logic [2:0] {REG_CMD, REG_WDATA, REG_RDATA, REG_STATUS, REG_CTRL, REG_NONE} srb_reg_type;
endpackage : srb_pkg

// ==== srb_if.sv ====
// Link between memory controller and memory device
`timescale 1ns/100ps
interface srb_if #(
	parameter int COL_W = 9,
	parameter int DW = 32
) (
	input wire logic clk_sys_i
);
	import srb_pkg::*;

	srb_cmd_type cmd;
	logic [1:0] bank;
	logic [COL_W-1:0] col;
	logic auto_pre;
	logic dqm;
	logic [DW-1:0] ctl_dq;
	logic ctl_oe;
	logic [DW-1:0] dev_dq;
	logic dev_oe;
	logic [DW-1:0] dq;
	logic contention;

	// Wire level of the shared data pins; device wins when both drive
	assign dq = dev_oe ? dev_dq : ctl_dq;
	assign contention = dev_oe & ctl_oe;

	modport dev (input cmd, bank, col, auto_pre, dqm, dq, output dev_dq, dev_oe);
	modport ctl (output cmd, bank, col, auto_pre, dqm, ctl_dq, ctl_oe, input dq, dev_oe);
endinterface : srb_if

// ==== srb_dev.sv ====
// Device end: read burst engine, read latency pipeline, output masking
`timescale 1ns/100ps
module srb_dev #(
	parameter int COL_W = 9,
	parameter int DW = 32
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	srb_if.dev link,
	input wire logic [1:0] cfg_latency_i,
	input wire srb_pkg::srb_burst_type cfg_burst_i,
	output logic row_close_o,
	output logic [1:0] row_close_bank_o,
	output logic [3:0] bank_open_o,
	output logic access_err_o
);
	import srb_pkg::*;

	localparam int AW = COL_W + 2;

	// Storage for every column of every bank, one open row each
	logic [DW-1:0] mem [0:(2**AW)-1];

	// Column bits that wrap inside the burst block
	function automatic logic [COL_W-1:0] burst_mask(input srb_burst_type b);
		unique case (b)
			BURST_1: burst_mask = '0;
			BURST_2: burst_mask = COL_W'(1);
			BURST_4: burst_mask = COL_W'(3);
			BURST_8: burst_mask = COL_W'(7);
			BURST_PAGE: burst_mask = '1;
			default: burst_mask = '0;
		endcase
	endfunction : burst_mask

	function automatic logic [COL_W-1:0] next_col(
		input logic [COL_W-1:0] c,
		input logic [COL_W-1:0] m
	);
		next_col = (c & ~m) | ((c + 1'b1) & m);
	endfunction : next_col

	logic act_q;
	logic act_d;
	logic page_q;
	logic page_d;
	logic ap_q;
	logic ap_d;
	logic fin_q;
	logic fin_d;
	logic [1:0] bank_q;
	logic [1:0] bank_d;
	logic [COL_W-1:0] col_q;
	logic [COL_W-1:0] col_d;
	logic [COL_W-1:0] left_q;
	logic [COL_W-1:0] left_d;
	logic [2:0] pv_q;
	logic [2:0] pv_d;
	logic [DW-1:0] pd_q [0:2];
	logic [DW-1:0] pd_d [0:2];
	logic [DW-1:0] dq_q;
	logic [DW-1:0] dq_d;
	logic oe_q;
	logic oe_d;
	logic dqm_q;
	logic dqm_d;
	logic skip_q;
	logic skip_d;
	logic [3:0] open_q;
	logic [3:0] open_d;
	logic close_q;
	logic close_d;
	logic [1:0] cbank_q;
	logic [1:0] cbank_d;
	logic err_q;
	logic err_d;

	logic [1:0] lat;
	logic [COL_W-1:0] mask;
	logic is_rd;
	logic is_wr;
	logic is_pre;
	logic in_flight;
	logic wr_ok;
	logic iss_v;
	logic [AW-1:0] iss_addr;
	logic lead;
	logic cur;

	always_comb begin
		lat = (cfg_latency_i == 2'd0) ? 2'd1 : cfg_latency_i;
		mask = burst_mask(cfg_burst_i);
		is_rd = (link.cmd == CMD_READ);
		is_wr = (link.cmd == CMD_WRITE);
		is_pre = (link.cmd == CMD_PRE);
		in_flight = act_q | (|pv_q);
		act_d = act_q;
		page_d = page_q;
		ap_d = ap_q;
		bank_d = bank_q;
		col_d = col_q;
		left_d = left_q;
		fin_d = 1'b0;
		iss_v = 1'b0;
		iss_addr = {bank_q, col_q};
		open_d = open_q;
		close_d = fin_q;
		cbank_d = bank_q;
		err_d = (is_rd | is_wr) & ~open_q[link.bank];
		// A write is dropped if the clock before it held a write issued during a read with the mask low on the clock before that
		skip_d = is_wr & in_flight & ~dqm_q; // R11
		wr_ok = is_wr & ~skip_q & ~link.dqm;
		if (is_rd) begin
			// Column, bank and auto close taken with the command
			iss_v = 1'b1; // R1 R7 R6
			iss_addr = {link.bank, link.col};
			bank_d = link.bank;
			page_d = (cfg_burst_i == BURST_PAGE);
			// Auto close has no meaning for a page burst
			ap_d = link.auto_pre & (cfg_burst_i != BURST_PAGE);
			col_d = next_col(link.col, mask); // R19
			left_d = mask;
			act_d = |mask;
			fin_d = link.auto_pre & ~(|mask); // R2
		end else if (act_q & (is_wr | link.cmd == CMD_BST | (is_pre & link.bank == bank_q))) begin
			// Stop fetching; words already fetched still drain, except on a write, which clears them
			act_d = 1'b0; // R16 R13
		end else if (act_q) begin
			iss_v = 1'b1; // R3
			col_d = next_col(col_q, mask); // R5 R19
			left_d = left_q - 1'b1;
			if (!page_q && left_q == COL_W'(1)) begin
				act_d = 1'b0;
				// Close lands on the edge an optimal precharge would
				fin_d = ap_q; // R2 R15
			end
		end
		if (is_pre) begin
			close_d = 1'b1; // R15
			cbank_d = link.bank;
		end
		if (close_q) begin
			open_d[cbank_q] = 1'b0;
		end
		if (link.cmd == CMD_ACT) begin
			open_d[link.bank] = 1'b1;
		end
		pv_d = {pv_q[1:0], iss_v};
		pd_d[0] = mem[iss_addr];
		pd_d[1] = pd_q[0];
		pd_d[2] = pd_q[1];
		if (is_wr) begin
			pv_d = 3'h0; // R11
		end
		unique case (lat)
			2'd1: begin
				lead = iss_v;
				cur = pv_q[0];
				dq_d = pd_q[0];
			end
			2'd2: begin
				lead = pv_q[0];
				cur = pv_q[1];
				dq_d = pd_q[1];
			end
			default: begin
				lead = pv_q[1];
				cur = pv_q[2];
				dq_d = pd_q[2];
			end
		endcase
		// Drive one clock ahead of valid data, release after the last word
		oe_d = (lead | cur) & ~dqm_q & ~is_wr; // R18 R4 R10 R11
		dqm_d = link.dqm;
	end

	always_ff @(posedge clk_sys_i) begin
		if (ce_i && wr_ok) begin
			mem[{link.bank, link.col}] <= link.dq;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			act_q <= 1'b0;
			page_q <= 1'b0;
			ap_q <= 1'b0;
			fin_q <= 1'b0;
			bank_q <= 2'h0;
			col_q <= '0;
			left_q <= '0;
			pv_q <= 3'h0;
			dq_q <= '0;
			oe_q <= 1'b0;
			dqm_q <= 1'b0;
			skip_q <= 1'b0;
			open_q <= 4'h0;
			close_q <= 1'b0;
			cbank_q <= 2'h0;
			err_q <= 1'b0;
		end else if (ce_i) begin
			act_q <= act_d;
			page_q <= page_d;
			ap_q <= ap_d;
			fin_q <= fin_d;
			bank_q <= bank_d;
			col_q <= col_d;
			left_q <= left_d;
			pv_q <= pv_d;
			pd_q <= pd_d;
			dq_q <= dq_d;
			oe_q <= oe_d;
			dqm_q <= dqm_d;
			skip_q <= skip_d;
			open_q <= open_d;
			close_q <= close_d;
			cbank_q <= cbank_d;
			err_q <= err_d;
		end
	end

	assign link.dev_dq = dq_q;
	assign link.dev_oe = oe_q;
	assign row_close_o = close_q;
	assign row_close_bank_o = cbank_q;
	assign bank_open_o = open_q;
	assign access_err_o = err_q;
endmodule : srb_dev

// ==== srb_ctl.sv ====
// Controller end: AXI4-Lite register slave that sequences link commands
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "srb_map.svh"
module srb_ctl #(
	parameter int COL_W = 9,
	parameter int DW = 32,
	parameter int AW = 8
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	srb_if.ctl link,
	output logic [1:0] cfg_latency_o,
	output srb_pkg::srb_burst_type cfg_burst_o
);
	import srb_pkg::*;

	localparam int BW = COL_W + 2;

	function automatic srb_reg_type reg_sel(input logic [AW-1:0] a);
		logic [AW-1:0] w;
		w = {a[AW-1:2], 2'b00};
		if (w == AW'(`SRB_OFF_CMD)) reg_sel = REG_CMD;
		else if (w == AW'(`SRB_OFF_WDATA)) reg_sel = REG_WDATA;
		else if (w == AW'(`SRB_OFF_RDATA)) reg_sel = REG_RDATA;
		else if (w == AW'(`SRB_OFF_STATUS)) reg_sel = REG_STATUS;
		else if (w == AW'(`SRB_OFF_CTRL)) reg_sel = REG_CTRL;
		else reg_sel = REG_NONE;
	endfunction : reg_sel

	function automatic logic [31:0] strobe(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0] s
	);
		strobe = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) strobe[8*i +: 8] = nw[8*i +: 8];
		end
	endfunction : strobe

	logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
	logic [AW-1:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0] ws_q, ws_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic pend_q, pend_d;
	logic [31:0] cmdw_q, cmdw_d, wreg_q, wreg_d, ctrl_q, ctrl_d, rword_q, rword_d;
	logic [7:0] cnt_q, cnt_d;
	logic oep_q, oep_d;
	srb_ctl_state_type st_q, st_d;
	logic [BW-1:0] busy_q, busy_d;
	logic [7:0] trp_q [0:3];
	logic [7:0] trp_d [0:3];
	srb_cmd_type cmd_q, cmd_d;
	logic [1:0] bank_q, bank_d;
	logic [COL_W-1:0] col_q, col_d;
	logic ap_q, ap_d, dqm_q, dqm_d, coe_q, coe_d;
	logic [DW-1:0] cdq_q, cdq_d;

	srb_cmd_type code;
	srb_burst_type burst;
	logic [1:0] cbank;
	logic [1:0] lat;
	logic [3:0] blk;
	logic issue;
	logic [BW-1:0] tail;

	always_comb begin
		aw_d = aw_q; w_d = w_q; b_d = b_q; r_d = r_q;
		awa_d = awa_q; wd_d = wd_q; ws_d = ws_q; rd_d = rd_q;
		bresp_d = bresp_q; rresp_d = rresp_q;
		pend_d = pend_q; cmdw_d = cmdw_q; wreg_d = wreg_q; ctrl_d = ctrl_q;
		rword_d = rword_q; cnt_d = cnt_q; st_d = st_q;
		// No-operation unless a command goes out this cycle
		cmd_d = CMD_NOP; // R20
		bank_d = bank_q; col_d = col_q; ap_d = 1'b0; dqm_d = 1'b0;
		coe_d = 1'b0; cdq_d = cdq_q;
		code = srb_cmd_type'(cmdw_q[`SRB_CMD_CODE_LSB +: 3]);
		cbank = cmdw_q[`SRB_CMD_BANK_LSB +: 2];
		lat = ctrl_q[`SRB_CTRL_LAT_LSB +: 2];
		burst = srb_burst_type'(ctrl_q[`SRB_CTRL_BURST_LSB +: 3]);
		tail = BW'(lat) + BW'(2);
		for (int i = 0; i < 4; i++) begin
			blk[i] = (trp_q[i] != 8'h00);
			trp_d[i] = blk[i] ? trp_q[i] - 8'h01 : 8'h00;
		end
		busy_d = (busy_q != '0) ? busy_q - 1'b1 : busy_q;
		s_axi_awready = ~aw_q & ~b_q;
		s_axi_wready = ~w_q & ~b_q;
		s_axi_arready = ~r_q;
		if (s_axi_awvalid & s_axi_awready) begin
			aw_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid & s_axi_wready) begin
			w_d = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		if (aw_q & w_q) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			b_d = 1'b1;
			bresp_d = `SRB_RESP_OKAY;
			unique case (reg_sel(awa_q))
				REG_CMD: if (!pend_q) begin
					pend_d = 1'b1;
					cmdw_d = strobe(cmdw_q, wd_q, ws_q);
				end
				REG_WDATA: wreg_d = strobe(wreg_q, wd_q, ws_q);
				REG_CTRL: ctrl_d = strobe(ctrl_q, wd_q, ws_q);
				REG_RDATA, REG_STATUS: ;
				default: bresp_d = `SRB_RESP_SLVERR;
			endcase
		end
		if (b_q & s_axi_bready) b_d = 1'b0;
		if (r_q & s_axi_rready) r_d = 1'b0;
		if (s_axi_arvalid & s_axi_arready) begin
			r_d = 1'b1;
			rresp_d = `SRB_RESP_OKAY;
			unique case (reg_sel(s_axi_araddr))
				REG_CMD: rd_d = cmdw_q;
				REG_WDATA: rd_d = wreg_q;
				REG_RDATA: rd_d = rword_q;
				REG_STATUS: begin
					rd_d = 32'h0000_0000;
					rd_d[`SRB_STAT_PEND_BIT] = pend_q;
					rd_d[`SRB_STAT_BUSY_BIT] = (busy_q != '0);
					rd_d[`SRB_STAT_BLOCK_LSB +: 4] = blk;
					rd_d[`SRB_STAT_COUNT_LSB +: 8] = cnt_q;
				end
				REG_CTRL: rd_d = ctrl_q;
				default: begin
					rd_d = 32'h0000_0000;
					rresp_d = `SRB_RESP_SLVERR;
				end
			endcase
		end
		issue = 1'b0;
		unique case (st_q)
			CS_IDLE: if (pend_q && !(code != CMD_NOP && blk[cbank])) begin // R14
				if (code == CMD_WRITE && busy_q != '0 && burst != BURST_1) begin
					// Read words still due: mask them before the write
					dqm_d = 1'b1; // R10
					st_d = CS_MASK1;
				end else if (code == CMD_WRITE && ((burst == BURST_1 && busy_q != '0)
						|| (ctrl_q[`SRB_CTRL_TURN_BIT] && (link.dev_oe || oep_q)))) begin
					// Wait out the last word, plus an idle clock if asked
					issue = 1'b0; // R17 R9 R8
				end else begin
					issue = 1'b1;
				end
			end
			CS_MASK1: begin
				dqm_d = 1'b1; // R10
				st_d = CS_MASK2;
			end
			CS_MASK2: begin
				if (ctrl_q[`SRB_CTRL_TURN_BIT] && (link.dev_oe || oep_q)) begin
					// Keep masking until the read drivers have been off a full clock
					dqm_d = 1'b1; // R9
				end else begin
					issue = 1'b1;
					st_d = CS_IDLE;
				end
			end
		endcase
		if (issue) begin
			pend_d = 1'b0;
			cmd_d = code;
			bank_d = cbank;
			col_d = cmdw_q[`SRB_CMD_COL_LSB +: COL_W];
			ap_d = cmdw_q[`SRB_CMD_AP_BIT]; // R1
			unique case (code)
				CMD_READ: busy_d = (burst == BURST_PAGE) ? '1
					: tail + (BW'(1) << burst); // R7 R6
				CMD_WRITE: begin
					// Mask low so the written word is not blocked
					dqm_d = 1'b0; // R12
					coe_d = 1'b1;
					cdq_d = wreg_q;
					busy_d = '0;
				end
				CMD_PRE, CMD_BST: begin
					if (busy_q > tail) busy_d = tail; // R13 R16
					if (code == CMD_PRE) trp_d[cbank] = 8'(`SRB_ROW_PRECHARGE_CYC); // R14
				end
				default: ;
			endcase
		end
		// Data valid from the second clock the device drives
		oep_d = link.dev_oe;
		if (link.dev_oe && oep_q) begin
			rword_d = link.dq; // R3
			cnt_d = cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
			awa_q <= '0; wd_q <= 32'h0; ws_q <= 4'h0; rd_q <= 32'h0;
			bresp_q <= `SRB_RESP_OKAY; rresp_q <= `SRB_RESP_OKAY;
			pend_q <= 1'b0; cmdw_q <= 32'h0; wreg_q <= 32'h0;
			ctrl_q <= `SRB_CTRL_RESET; rword_q <= 32'h0; cnt_q <= 8'h00;
			oep_q <= 1'b0; st_q <= CS_IDLE; busy_q <= '0;
			for (int i = 0; i < 4; i++) trp_q[i] <= 8'h00;
			cmd_q <= CMD_NOP; bank_q <= 2'h0; col_q <= '0; ap_q <= 1'b0;
			dqm_q <= 1'b0; coe_q <= 1'b0; cdq_q <= '0;
		end else if (ce_i) begin
			aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d;
			awa_q <= awa_d; wd_q <= wd_d; ws_q <= ws_d; rd_q <= rd_d;
			bresp_q <= bresp_d; rresp_q <= rresp_d;
			pend_q <= pend_d; cmdw_q <= cmdw_d; wreg_q <= wreg_d;
			ctrl_q <= ctrl_d; rword_q <= rword_d; cnt_q <= cnt_d;
			oep_q <= oep_d; st_q <= st_d; busy_q <= busy_d;
			trp_q <= trp_d;
			cmd_q <= cmd_d; bank_q <= bank_d; col_q <= col_d; ap_q <= ap_d;
			dqm_q <= dqm_d; coe_q <= coe_d; cdq_q <= cdq_d;
		end
	end

	assign s_axi_bvalid = b_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = r_q;
	assign s_axi_rdata = rd_q;
	assign s_axi_rresp = rresp_q;
	assign link.cmd = cmd_q;
	assign link.bank = bank_q;
	assign link.col = col_q;
	assign link.auto_pre = ap_q;
	assign link.dqm = dqm_q;
	assign link.ctl_dq = cdq_q;
	assign link.ctl_oe = coe_q;
	assign cfg_latency_o = ctrl_q[`SRB_CTRL_LAT_LSB +: 2];
	assign cfg_burst_o = srb_burst_type'(ctrl_q[`SRB_CTRL_BURST_LSB +: 3]);
endmodule : srb_ctl

// ==== srb_monitor.sv ====
// Checker for timing relations on the read-burst link
`timescale 1ns/100ps
module srb_monitor (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire srb_pkg::srb_cmd_type cmd,
	input wire logic [1:0] bank,
	input wire logic dqm,
	input wire logic ctl_oe,
	input wire logic dev_oe,
	input wire logic contention,
	input wire logic [1:0] cfg_latency_i,
	input wire srb_pkg::srb_burst_type cfg_burst_i
);
	import srb_pkg::*;
	logic [3:0] idle_q;
	logic [3:0] idle_d;

	// Cycles since the last read, saturating
	always_comb begin
		idle_d = idle_q;
		if (cmd == CMD_READ) begin
			idle_d = 4'h0;
		end else if (idle_q != 4'hF) begin
			idle_d = idle_q + 4'h1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			idle_q <= 4'hF;
		end else begin
			idle_q <= idle_d;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	sequence rd2_sq;
		cmd == CMD_READ && cfg_latency_i == 2'h2 && !dqm;
	endsequence
	sequence rd3_sq;
		(cmd == CMD_READ && cfg_latency_i == 2'h3 && !dqm) ##1 !dqm;
	endsequence
	sequence bst2_sq;
		(cmd == CMD_BST && cfg_latency_i == 2'h2) ##1 (cmd == CMD_NOP) [*2];
	endsequence

	a_first_lat2: assert property (rd2_sq |-> ##2 dev_oe)
		else $error("read at latency two not driven in time");
	a_first_lat3: assert property (rd3_sq |-> ##2 dev_oe)
		else $error("read at latency three not driven in time");
	a_idle_release: assert property ((idle_q >= 4'hC && cfg_burst_i != BURST_PAGE) |-> !dev_oe)
		else $error("data pins still driven after burst end");
	a_mask_two_clk: assert property (dqm |-> ##2 !dev_oe)
		else $error("mask did not release read drivers after two clocks");
	a_write_release: assert property (cmd == CMD_WRITE |=> !dev_oe)
		else $error("device drives after write");
	a_mask_before_wr: assert property ((cmd == CMD_WRITE && $past(dev_oe)) |-> ($past(dqm, 2) && $past(dqm)))
		else $error("write cut into read without two mask clocks");
	a_write_mask_low: assert property (ctl_oe |-> (cmd == CMD_WRITE && !dqm))
		else $error("write data driven with mask high or without write");
	a_no_contention: assert property (!contention)
		else $error("both ends drive the data pins");
	a_bst_stop: assert property (bst2_sq |=> !dev_oe)
		else $error("burst terminate did not stop the read");
	a_pre_wait: assert property (cmd != CMD_NOP |-> !(($past(cmd) == CMD_PRE && $past(bank) == bank)
		|| ($past(cmd, 2) == CMD_PRE && $past(bank, 2) == bank)
		|| ($past(cmd, 3) == CMD_PRE && $past(bank, 3) == bank)))
		else $error("command to bank inside precharge time");
endmodule : srb_monitor

// ==== tb.sv ====
// Testbench: controller and device joined over the link, driven over AXI4-Lite
`timescale 1ns/100ps
`include "srb_map.svh"
module tb;
	import srb_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic bready = 1'b1;
	logic rready = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, row_close, acc_err;
	logic [1:0] bresp, rresp, lat, rc_bank;
	logic [31:0] rdata, d;
	logic [3:0] bank_open;
	logic [8:0] col;
	logic prev_oe = 1'b0;
	srb_burst_type bl;
	logic [31:0] mem_m [512];
	logic [31:0] wq [$];
	logic [33:0] rq [$];
	logic [1:0] bq [$];
	int n_fail = 0, compares = 0, seed = 32703, cyc = 0, t_rd = 0, t_end = 0, n_words = 0;
	int n_rc = 0, rc0 = 0, w0 = 0, n_err = 0, e0 = 0;

	srb_if #(.COL_W(9), .DW(32)) srb_if_i (.clk_sys_i(clk_sys_i));
	srb_dev #(.COL_W(9), .DW(32)) srb_dev_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
		.link(srb_if_i), .cfg_latency_i(lat), .cfg_burst_i(bl), .row_close_o(row_close),
		.row_close_bank_o(rc_bank), .bank_open_o(bank_open), .access_err_o(acc_err));
	srb_ctl #(.COL_W(9), .DW(32), .AW(8)) srb_ctl_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.ce_i(ce_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.link(srb_if_i), .cfg_latency_o(lat), .cfg_burst_o(bl));
	srb_monitor srb_monitor_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd(srb_if_i.cmd),
		.bank(srb_if_i.bank), .dqm(srb_if_i.dqm), .ctl_oe(srb_if_i.ctl_oe),
		.dev_oe(srb_if_i.dev_oe), .contention(srb_if_i.contention), .cfg_latency_i(lat),
		.cfg_burst_i(bl));

	initial begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	task automatic test_done;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	task automatic report(input bit bad, input string what);
		compares++;
		if (bad) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask : report
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		report(got !== exp, "link word");
	endtask : chk_word
	task automatic chk_bus(input logic [33:0] got, input logic [33:0] exp);
		report(got !== exp, "bus response");
	endtask : chk_bus
	task automatic chk_small(input logic [3:0] got, input logic [3:0] exp);
		report(got !== exp, "status flag");
	endtask : chk_small
	task automatic chk_cnt(input int got, input int exp);
		report(got != exp, "word count");
	endtask : chk_cnt

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		bit aw_done;
		bit w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		bq.push_back(er);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk_sys_i);
			if (awvalid && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk_sys_i); while (bvalid !== 1'b1);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input bit chk, input logic [33:0] e,
		output logic [31:0] dv);
		if (chk) rq.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk_sys_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_sys_i); while (rvalid !== 1'b1);
		dv = rdata;
	endtask : axi_rd

	task automatic send(input srb_cmd_type c, input logic ap, input logic [8:0] cl);
		axi_wr(`SRB_OFF_CMD, {15'h0, cl, 2'h0, 2'h1, ap, c}, `SRB_RESP_OKAY);
	endtask : send

	task automatic set_cfg(input logic [1:0] m, input logic [2:0] b, input logic t);
		axi_wr(`SRB_OFF_CTRL, {23'h0, t, 1'b0, b, 2'h0, m}, `SRB_RESP_OKAY);
	endtask : set_cfg

	// Status poll plus margin so the tail of a burst has landed
	task automatic wait_idle;
		logic [31:0] s;
		s = 32'h3;
		while (s[1:0] != 2'h0) axi_rd(`SRB_OFF_STATUS, 1'b0, 34'h0, s);
		repeat (8) @(posedge clk_sys_i);
	endtask : wait_idle

	task automatic put_word(input logic [8:0] c);
		axi_wr(`SRB_OFF_WDATA, mem_m[c], `SRB_RESP_OKAY);
		send(CMD_WRITE, 1'b0, c);
		wait_idle();
	endtask : put_word

	// Words of a burst wrap inside the aligned block of its length
	task automatic expect_block(input logic [8:0] s, input int len, input int cnt);
		logic [8:0] msk;
		msk = 9'(len - 1);
		for (int k = 0; k < cnt; k++) wq.push_back(mem_m[(s & ~msk) | ((s + 9'(k)) & msk)]);
	endtask : expect_block

	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (acc_err === 1'b1) n_err <= n_err + 1;
		prev_oe <= srb_if_i.dev_oe;
		if (srb_if_i.cmd == CMD_READ) t_rd <= cyc;
		if (srb_if_i.cmd == CMD_BST || srb_if_i.cmd == CMD_PRE) t_end <= cyc;
		if (row_close === 1'b1) begin
			n_rc <= n_rc + 1;
			chk_small({2'h0, rc_bank}, 4'h1);
		end
		if (srb_if_i.dev_oe === 1'b1 && prev_oe === 1'b1) begin
			n_words <= n_words + 1;
			if (wq.size() > 0) chk_word(srb_if_i.dq, wq.pop_front());
			else report(1'b1, "unexpected word");
		end
		if (rvalid && rready && rq.size() > 0) chk_bus({rresp, rdata}, rq.pop_front());
		if (bvalid && bready && bq.size() > 0) chk_bus({bresp, 32'h0}, {bq.pop_front(), 32'h0});
	end

	initial begin
		#100000;
		report(1'b1, "timeout");
		test_done();
	end

	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		axi_rd(`SRB_OFF_CTRL, 1'b1, {`SRB_RESP_OKAY, `SRB_CTRL_RESET}, d);
		axi_rd(8'h40, 1'b1, {`SRB_RESP_SLVERR, 32'h0}, d);
		axi_wr(8'h40, 32'h0, `SRB_RESP_SLVERR);
		// Byte strobes: only the low half of the second write may land
		d = $random(seed);
		axi_wr(`SRB_OFF_WDATA, d, `SRB_RESP_OKAY);
		wstrb <= 4'h3;
		axi_wr(`SRB_OFF_WDATA, ~d, `SRB_RESP_OKAY);
		wstrb <= 4'hF;
		axi_rd(`SRB_OFF_WDATA, 1'b1, {`SRB_RESP_OKAY, d[31:16], ~d[15:0]}, d);
		$display("test registers done");
		set_cfg(2'h2, 3'h0, 1'b0);
		send(CMD_ACT, 1'b0, 9'h000);
		for (int i = 0; i < 10; i++) begin
			col = (i < 8) ? 9'(i) : 9'(502 + i);
			mem_m[col] = $random(seed);
			put_word(col);
		end
		$display("test fill done");
		// Frozen clocks leave the status register as it was
		axi_rd(`SRB_OFF_STATUS, 1'b0, 34'h0, d);
		ce_i <= 1'b0;
		repeat (2 + ($random(seed) & 3)) @(posedge clk_sys_i);
		ce_i <= 1'b1;
		axi_rd(`SRB_OFF_STATUS, 1'b1, {`SRB_RESP_OKAY, d}, d);
		for (int m = 2; m < 4; m++) begin
			for (int b = 0; b < 4; b++) begin
				set_cfg(2'(m), 3'(b), 1'b0);
				col = 9'($random(seed) & 7);
				expect_block(col, 1 << b, 1 << b);
				send(CMD_READ, 1'b0, col);
				wait_idle();
				chk_cnt(wq.size(), 0);
			end
		end
		$display("test bursts done");
		set_cfg(2'h2, 3'h4, 1'b0);
		expect_block(9'h1FE, 512, 10);
		w0 = n_words;
		send(CMD_READ, 1'b0, 9'h1FE);
		send(CMD_BST, 1'b0, 9'h000);
		wait_idle();
		chk_cnt(n_words - w0, t_end - t_rd);
		wq.delete();
		$display("test page done");
		set_cfg(2'h2, 3'h3, 1'b0);
		expect_block(9'h000, 8, 8);
		w0 = n_words;
		send(CMD_READ, 1'b0, 9'h000);
		send(CMD_PRE, 1'b0, 9'h000);
		send(CMD_ACT, 1'b0, 9'h000);
		wait_idle();
		chk_cnt(n_words - w0, (t_end - t_rd < 8) ? t_end - t_rd : 8);
		chk_small(bank_open, 4'h2);
		wq.delete();
		set_cfg(2'h2, 3'h2, 1'b0);
		expect_block(9'h000, 4, 4);
		rc0 = n_rc;
		send(CMD_READ, 1'b1, 9'h000);
		wait_idle();
		chk_cnt(n_rc - rc0, 1);
		chk_small(bank_open, 4'h0);
		// A read to the closed bank is flagged once
		e0 = n_err;
		expect_block(9'h000, 4, 4);
		send(CMD_READ, 1'b0, 9'h000);
		wait_idle();
		chk_cnt(n_err - e0, 1);
		send(CMD_ACT, 1'b0, 9'h000);
		$display("test row close done");
		for (int t = 0; t < 3; t++) begin
			set_cfg(2'h2, (t == 2) ? 3'h0 : 3'h3, 1'(t == 1));
			mem_m[9] = $random(seed);
			axi_wr(`SRB_OFF_WDATA, mem_m[9], `SRB_RESP_OKAY);
			expect_block(9'h000, 8, 8);
			send(CMD_READ, 1'b0, 9'h000);
			send(CMD_WRITE, 1'b0, 9'h009);
			wait_idle();
			wq.delete();
			set_cfg(2'h2, 3'h0, 1'b0);
			expect_block(9'h009, 1, 1);
			send(CMD_READ, 1'b0, 9'h009);
			wait_idle();
			chk_cnt(wq.size(), 0);
		end
		$display("test read to write done");
		test_done();
	end
endmodule : tb
